// file: verilog/hsc_switch_ctrl.sv
/*
 * High-side switch source selection, timer B settings and supply fault
 * shutdown. Assumes a decoded byte register port from the serial front end
 * and fault levels synchronous to the core clock.
 */
`default_nettype none
module hsc_switch_ctrl #(
	parameter int unsigned P_TICK_CYCLES = hsc_pkg::TICK_CYCLES
) (
	input  wire logic       i_clk,
	input  wire logic       i_reset_n,
	input  wire logic       i_soft_reset,
	input  wire logic       i_wr_en,
	input  wire logic       i_rd_en,
	input  wire logic [6:0] i_addr,
	input  wire logic [7:0] i_wr_data,
	output var  logic [7:0] o_rd_data,
	input  wire logic [7:0] i_timer_a_config,
	input  wire logic [7:0] i_pulse_a_duty,
	input  wire logic [7:0] i_pulse_b_duty,
	input  wire logic       i_supply_ov,
	input  wire logic       i_supply_uv,
	input  wire logic [3:0] i_overcurrent,
	input  wire logic [3:0] i_overtemp,
	input  wire logic       i_restart_clear,
	input  wire logic       i_cyclic_sense,
	output var  logic [3:0] o_switch_on,
	output var  logic       o_timer_a_clear
);
	logic [7:0]  tmb_q;
	logic [7:0]  shd_q;
	logic [7:0]  sw_q [2];
	logic [2:0]  src [4];
	logic [3:0]  hw_clr;
	logic [3:0]  levels;
	logic [1:0]  pwm;
	logic [1:0]  tmr_out;
	logic [7:0]  duty [2];
	logic [23:0] tick_cnt_q;
	logic        tick_q;
	logic [11:0] step_q;
	logic [7:0]  phase_q;
	logic [7:0]  ta_cfg_q;
	logic        fault;
	logic        wipe_timer;
	logic        tb_wr;

	hsc_timer_if tif [2] ();

	// supply fault: each direction can be masked on its own
	assign fault = (i_supply_ov && !shd_q[hsc_pkg::OV_DIS_BIT])
		|| (i_supply_uv && !shd_q[hsc_pkg::UV_DIS_BIT]);
	assign wipe_timer = i_restart_clear && i_cyclic_sense;
	assign tb_wr = i_wr_en && (i_addr == hsc_pkg::ADDR_TIMER_B);

	// four switch fields, two per register
	assign src[0] = sw_q[0][hsc_pkg::SRC_LO_LSB +: 3];
	assign src[1] = sw_q[0][hsc_pkg::SRC_HI_LSB +: 3];
	assign src[2] = sw_q[1][hsc_pkg::SRC_LO_LSB +: 3];
	assign src[3] = sw_q[1][hsc_pkg::SRC_HI_LSB +: 3];

	// hardware clears per switch: protection trip, unrecovered fault, restart
	assign hw_clr = i_overcurrent | i_overtemp
		| {4{fault && !shd_q[hsc_pkg::REC_BIT]}}
		| {4{i_restart_clear}};

	// timer B settings; reserved bits never stored
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			tmb_q <= hsc_pkg::RESET_VAL;
		end else if (i_soft_reset || wipe_timer) begin
			tmb_q <= hsc_pkg::RESET_VAL;
		end else if (tb_wr) begin
			tmb_q <= i_wr_data & hsc_pkg::MASK_TIMER;
		end
	end

	// shutdown control; clears on restart like the switch fields
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			shd_q <= hsc_pkg::RESET_VAL;
		end else if (i_soft_reset || i_restart_clear) begin
			shd_q <= hsc_pkg::RESET_VAL;
		end else if (i_wr_en && (i_addr == hsc_pkg::ADDR_SHUTDOWN)) begin
			shd_q <= i_wr_data & hsc_pkg::MASK_SHUTDOWN;
		end
	end

	// switch source registers; the hardware clear is written last so it wins
	for (genvar g = 0; g < 2; g++) begin : g_sw
		localparam logic [6:0] ADDR = (g == 0) ? hsc_pkg::ADDR_SW_A : hsc_pkg::ADDR_SW_B;
		always_ff @(posedge i_clk or negedge i_reset_n) begin
			if (!i_reset_n) begin
				sw_q[g] <= hsc_pkg::RESET_VAL;
			end else if (i_soft_reset) begin
				sw_q[g] <= hsc_pkg::RESET_VAL;
			end else begin
				if (i_wr_en && (i_addr == ADDR)) begin
					sw_q[g] <= i_wr_data & hsc_pkg::MASK_SW;
				end
				if (hw_clr[2*g]) begin
					sw_q[g][hsc_pkg::SRC_LO_LSB +: 3] <= hsc_pkg::SRC_OFF;
				end
				if (hw_clr[2*g+1]) begin
					sw_q[g][hsc_pkg::SRC_HI_LSB +: 3] <= hsc_pkg::SRC_OFF;
				end
			end
		end
	end

	// read port: registered data, unmapped addresses read zero
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rd_data <= 8'h00;
		end else if (!i_rd_en) begin
			o_rd_data <= 8'h00;
		end else if (i_addr == hsc_pkg::ADDR_TIMER_B) begin
			o_rd_data <= tmb_q;
		end else if (i_addr == hsc_pkg::ADDR_SHUTDOWN) begin
			o_rd_data <= shd_q;
		end else if (i_addr == hsc_pkg::ADDR_SW_A) begin
			o_rd_data <= sw_q[0];
		end else if (i_addr == hsc_pkg::ADDR_SW_B) begin
			o_rd_data <= sw_q[1];
		end else begin
			o_rd_data <= 8'h00;
		end
	end

	// 0.1 ms tick shared by both timers
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			tick_cnt_q <= 24'h000000;
			tick_q     <= 1'b0;
		end else if (tick_cnt_q == 24'(P_TICK_CYCLES - 1)) begin
			tick_cnt_q <= 24'h000000;
			tick_q     <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 24'h000001;
			tick_q     <= 1'b0;
		end
	end

	// timer A settings live elsewhere; a change of them restarts the timer
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ta_cfg_q <= hsc_pkg::RESET_VAL;
		end else begin
			ta_cfg_q <= i_timer_a_config;
		end
	end

	assign tif[0].on_code  = i_timer_a_config[hsc_pkg::ON_LSB +: 3];
	assign tif[0].per_code = i_timer_a_config[hsc_pkg::PER_LSB +: 3];
	assign tif[0].start    = (i_timer_a_config != ta_cfg_q);
	assign tif[1].on_code  = tmb_q[hsc_pkg::ON_LSB +: 3];
	assign tif[1].per_code = tmb_q[hsc_pkg::PER_LSB +: 3];
	assign tif[1].start    = tb_wr;

	for (genvar t = 0; t < 2; t++) begin : g_tmr
		assign tif[t].tick = tick_q;
		assign tmr_out[t]  = tif[t].out;
		hsc_cyclic_timer u_tmr (
			.i_clk     (i_clk),
			.i_reset_n (i_reset_n),
			.tif       (tif[t])
		);
	end

	// pulse generators: 255 phases so duty 255 never drops low
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			step_q  <= 12'h000;
			phase_q <= 8'h00;
		end else if (step_q == 12'(hsc_pkg::PWM_STEP_CYCLES - 1)) begin
			step_q  <= 12'h000;
			phase_q <= (phase_q == 8'(hsc_pkg::PWM_STEPS - 1)) ? 8'h00 : phase_q + 8'h01;
		end else begin
			step_q <= step_q + 12'h001;
		end
	end

	assign duty[0] = i_pulse_a_duty;
	assign duty[1] = i_pulse_b_duty;
	for (genvar p = 0; p < 2; p++) begin : g_pwm
		assign pwm[p] = (duty[p] > phase_q);
	end

	// switch drive: fault forces all off, the fields keep state only while shutdown bit 4 enables recovery
	for (genvar s = 0; s < 4; s++) begin : g_out
		assign levels[s] = !fault && hsc_pkg::src_level(src[s], {pwm, tmr_out});
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_switch_on     <= 4'h0;
			o_timer_a_clear <= 1'b0;
		end else begin
			o_switch_on     <= levels;
			o_timer_a_clear <= wipe_timer;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	sequence s_fault_hold;
		fault && !shd_q[hsc_pkg::REC_BIT] && !i_soft_reset;
	endsequence

	chk_reserved_zero: assert property (((tmb_q & ~hsc_pkg::MASK_TIMER) == 0) &&
		((shd_q & ~hsc_pkg::MASK_SHUTDOWN) == 0) && ((sw_q[0] & ~hsc_pkg::MASK_SW) == 0))
		else $error("reserved bit set");
	chk_ov_shutdown: assert property (i_supply_ov && !shd_q[hsc_pkg::OV_DIS_BIT]
		|=> o_switch_on == 4'h0)
		else $error("switch on during overvoltage");
	chk_uv_shutdown: assert property (i_supply_uv && !shd_q[hsc_pkg::UV_DIS_BIT]
		|=> o_switch_on == 4'h0)
		else $error("switch on during undervoltage");
	chk_no_recovery: assert property (s_fault_hold ##1 !fault |-> src[0] == 0 && src[3] == 0)
		else $error("switch field kept without recovery");
	chk_on_source: assert property (src[1] == hsc_pkg::SRC_ON && !fault |=> o_switch_on[1])
		else $error("on source not driving");
	chk_prot_clear: assert property (i_overcurrent[2] || i_overtemp[2] |=> src[2] == 0)
		else $error("tripped switch field not cleared");
	chk_restart_timer: assert property (wipe_timer |=> tmb_q == 0 && o_timer_a_clear)
		else $error("timer settings kept on restart");
	chk_soft_reset: assert property (i_soft_reset |=> tmb_q == 0 && sw_q[1] == 0
		&& shd_q == 0)
		else $error("register not cleared by soft reset");
	chk_pwm_ends: assert property ((duty[0] == 8'hff |-> pwm[0]) and
		(duty[1] == 8'h00 |-> !pwm[1]))
		else $error("pulse extreme duty wrong");
endmodule // hsc_switch_ctrl
`default_nettype wire

// file: verilog/hsc_pkg.sv
/*
 * Constants, encodings and helper functions for the high-side switch
 * cyclic control block. Assumes a 125 MHz core clock.
 */
// What this block does
// - Timer B on-time codes 001-101 give 0.1 to 20 ms; 000 stops, output low.
// - On-time code 110 stops timer B with output high; 111 is reserved.
// - Timer B period codes 000-110 give 10 ms to 2 s; 111 reserved.
// - Writing a running on-time code starts the assigned timer, no extra command.
// - Restart clear with cyclic sensing also clears the timer period and on-time.
// - Reserved bits ignore writes and read back as zero.
// - Shutdown bit 6 low turns all switches off on supply overvoltage.
// - Shutdown bit 5 low turns all switches off on supply undervoltage.
// - Bit 4 high restores switches after the fault; low leaves them off.
// - Source codes: off, on, timer A, timer B, pulse A, pulse B; 110/111 reserved.
// - Select A holds switches 1,2; select B holds 3,4; bits 2:0 and 6:4.
// - Overcurrent or overtemperature clears that switch's source field to off.
// - All four registers reset to zero on power-on and soft reset.
// - Timer A uses the same on-time and period encodings as timer B.
// - Pulse duty 0 is off, 255 fully on, else on for duty/255.
`default_nettype none
package hsc_pkg;
	localparam logic [6:0] ADDR_TIMER_B  = 7'h0d;
	localparam logic [6:0] ADDR_SHUTDOWN = 7'h10;
	localparam logic [6:0] ADDR_SW_A     = 7'h14;
	localparam logic [6:0] ADDR_SW_B     = 7'h15;
	localparam logic [7:0] MASK_TIMER    = 8'h77;
	localparam logic [7:0] MASK_SHUTDOWN = 8'h70;
	localparam logic [7:0] MASK_SW       = 8'h77;
	localparam logic [7:0] RESET_VAL     = 8'h00;
	localparam int ON_LSB     = 4;
	localparam int PER_LSB    = 0;
	localparam int OV_DIS_BIT = 6;
	localparam int UV_DIS_BIT = 5;
	localparam int REC_BIT    = 4;
	localparam int SRC_LO_LSB = 0;
	localparam int SRC_HI_LSB = 4;

	typedef enum logic [2:0] {
		SRC_OFF   = 3'h0,
		SRC_ON    = 3'h1,
		SRC_TMR_A = 3'h2,
		SRC_TMR_B = 3'h3,
		SRC_PWM_A = 3'h4,
		SRC_PWM_B = 3'h5
	} hsc_src_t;
	localparam logic [2:0] ON_STOP_LOW  = 3'h0;
	localparam logic [2:0] ON_STOP_HIGH = 3'h6;
	localparam logic [2:0] ON_RESERVED  = 3'h7;
	localparam logic [2:0] PER_RESERVED = 3'h7;

	// timing: all timer figures are whole multiples of a 0.1 ms tick
	localparam int CLK_PERIOD_NS   = 8;
	localparam int TICK_NS         = 100000;
	localparam int TICK_CYCLES     = TICK_NS / CLK_PERIOD_NS;
	localparam int PWM_PERIOD_NS   = 5000000;
	localparam int PWM_STEPS       = 255;
	localparam int PWM_STEP_CYCLES = PWM_PERIOD_NS / (CLK_PERIOD_NS * PWM_STEPS);
	localparam logic [15:0] ON_0P1MS_TICKS = 16'h0001;
	localparam logic [15:0] ON_0P3MS_TICKS = 16'h0003;
	localparam logic [15:0] ON_1MS_TICKS   = 16'h000a;
	localparam logic [15:0] ON_10MS_TICKS  = 16'h0064;
	localparam logic [15:0] ON_20MS_TICKS  = 16'h00c8;
	localparam logic [15:0] PER_10MS_TICKS  = 16'h0064;
	localparam logic [15:0] PER_20MS_TICKS  = 16'h00c8;
	localparam logic [15:0] PER_50MS_TICKS  = 16'h01f4;
	localparam logic [15:0] PER_100MS_TICKS = 16'h03e8;
	localparam logic [15:0] PER_200MS_TICKS = 16'h07d0;
	localparam logic [15:0] PER_1S_TICKS    = 16'h2710;
	localparam logic [15:0] PER_2S_TICKS    = 16'h4e20;

	// on-time in ticks; zero for the stop and reserved codes
	function automatic logic [15:0] on_ticks(input logic [2:0] code);
		case (code)
			3'h1: on_ticks = ON_0P1MS_TICKS;
			3'h2: on_ticks = ON_0P3MS_TICKS;
			3'h3: on_ticks = ON_1MS_TICKS;
			3'h4: on_ticks = ON_10MS_TICKS;
			3'h5: on_ticks = ON_20MS_TICKS;
			default: on_ticks = 16'h0000;
		endcase
	endfunction

	// period in ticks; zero for the reserved code
	function automatic logic [15:0] per_ticks(input logic [2:0] code);
		case (code)
			3'h0: per_ticks = PER_10MS_TICKS;
			3'h1: per_ticks = PER_20MS_TICKS;
			3'h2: per_ticks = PER_50MS_TICKS;
			3'h3: per_ticks = PER_100MS_TICKS;
			3'h4: per_ticks = PER_200MS_TICKS;
			3'h5: per_ticks = PER_1S_TICKS;
			3'h6: per_ticks = PER_2S_TICKS;
			default: per_ticks = 16'h0000;
		endcase
	endfunction

	// level chosen by a source field; reserved codes act as off
	function automatic logic src_level(input logic [2:0] code, input logic [3:0] srcs);
		case (code)
			SRC_ON:    src_level = 1'b1;
			SRC_TMR_A: src_level = srcs[0];
			SRC_TMR_B: src_level = srcs[1];
			SRC_PWM_A: src_level = srcs[2];
			SRC_PWM_B: src_level = srcs[3];
			default:   src_level = 1'b0;
		endcase
	endfunction
endpackage
`default_nettype wire

// file: verilog/hsc_timer_if.sv
/*
 * Link between the switch controller and one cyclic timer.
 * Assumes both ends share the core clock.
 */
`default_nettype none
interface hsc_timer_if;
	logic [2:0] on_code;
	logic [2:0] per_code;
	logic       start;
	logic       tick;
	logic       out;
	modport ctl (output on_code, output per_code, output start, output tick, input out);
	modport tmr (input on_code, input per_code, input start, input tick, output out);
endinterface
`default_nettype wire

// file: verilog/hsc_cyclic_timer.sv
/*
 * One cyclic timer: on-time at the head of each period, then low.
 * Assumes a one-cycle tick every 0.1 ms from the controller.
 */
`default_nettype none
module hsc_cyclic_timer (
	input wire logic i_clk,
	input wire logic i_reset_n,
	hsc_timer_if.tmr tif
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ON   = 2'b01,
		ST_OFF  = 2'b11
	} hsc_tstate_t;

	hsc_tstate_t state_q;
	logic [15:0] cnt_q;
	logic        run_q;
	logic        running;
	logic [15:0] on_len;
	logic [15:0] per_len;
	logic [15:0] cnt_inc;

	assign on_len  = hsc_pkg::on_ticks(tif.on_code);
	assign per_len = hsc_pkg::per_ticks(tif.per_code);
	assign running = (on_len != 16'h0000) && (per_len != 16'h0000);
	assign cnt_inc = cnt_q + 16'h0001;

	// remembers whether a running code was already present
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			run_q <= 1'b0;
		end else begin
			run_q <= running;
		end
	end

	// start on a write or when a running code first appears, so no separate go bit
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_q <= ST_IDLE;
			cnt_q   <= 16'h0000;
		end else if (!running) begin
			state_q <= ST_IDLE;
			cnt_q   <= 16'h0000;
		end else if (tif.start || !run_q) begin
			state_q <= ST_ON;
			cnt_q   <= 16'h0000;
		end else if (tif.tick) begin
			// compare with >= so a period shortened mid-cycle still wraps
			if (cnt_inc >= per_len) begin
				state_q <= ST_ON;
				cnt_q   <= 16'h0000;
			end else begin
				cnt_q <= cnt_inc;
				if (cnt_inc == on_len) begin
					state_q <= ST_OFF;
				end
			end
		end
	end

	// stopped timers hold low, or high for the hold-high code
	assign tif.out = (state_q == ST_ON) ||
		((state_q == ST_IDLE) && (tif.on_code == hsc_pkg::ON_STOP_HIGH));

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	sequence s_code_held(logic [2:0] c);
		(tif.on_code == c) ##1 (tif.on_code == c);
	endsequence

	chk_stop_low_out: assert property (s_code_held(hsc_pkg::ON_STOP_LOW) |-> !tif.out)
		else $error("stopped timer drives high");
	chk_stop_high_out: assert property (s_code_held(hsc_pkg::ON_STOP_HIGH) |-> tif.out)
		else $error("hold-high timer drives low");
	chk_start_restart: assert property (tif.start && running |=> state_q == ST_ON && cnt_q == 0)
		else $error("timer did not restart on write");
	chk_on_ends: assert property ((state_q == ST_ON) && tif.tick && running && !tif.start &&
		(cnt_inc == on_len) && (cnt_inc < per_len) && $stable(tif.on_code) |=> !tif.out)
		else $error("on-time did not end on time");
endmodule // hsc_cyclic_timer
`default_nettype wire

// file: bench/hsc_load_model.sv
/*
 * Behavioural model of the four loads on the switch outputs.
 * Assumes the bench commands a short or overheating per switch.
 */
`default_nettype none
module hsc_load_model (
	input  wire logic [3:0] i_switch_on,
	input  wire logic [3:0] i_short,
	input  wire logic [3:0] i_hot,
	output var  logic [3:0] o_overcurrent,
	output var  logic [3:0] o_overtemp
);
	timeunit 1ns;
	timeprecision 1ps;
	// a shorted load draws excess current only while its switch drives it
	assign o_overcurrent = i_switch_on & i_short;
	// heat outlasts the drive, so overtemperature follows the command alone
	assign o_overtemp = i_hot;
endmodule // hsc_load_model
`default_nettype wire

// file: bench/testbench.sv
/*
 * Self-checking bench: register access, source selection, both cyclic
 * timers, pulse limits, supply faults, hardware clears and restart.
 * Assumes the design files and the load model are compiled first.
 */
`default_nettype none
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin err_count++; \
	$display("BAD %s expected %0h seen %0h", nm, exp, got); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TK = 4; // short tick keeps timer runs brief
	logic       i_clk = 1'b0, i_reset_n = 1'b0, i_soft_reset = 1'b0;
	logic       i_wr_en = 1'b0, i_rd_en = 1'b0, i_supply_ov = 1'b0, i_supply_uv = 1'b0;
	logic       i_restart_clear = 1'b0, i_cyclic_sense = 1'b0, o_timer_a_clear;
	logic [6:0] i_addr = 7'h00;
	logic [7:0] i_wr_data = 8'h00, i_timer_a_config = 8'h00, o_rd_data;
	logic [7:0] i_pulse_a_duty = 8'h00, i_pulse_b_duty = 8'h00;
	logic [3:0] i_overcurrent, i_overtemp, o_switch_on, short_q = 4'h0, hot_q = 4'h0;
	int         err_count = 0, tests_run = 0;
	int         on_t [6] = '{0, 1, 3, 10, 100, 200};
	int         per_t [5] = '{100, 200, 500, 1000, 2000};
	logic [6:0] adr [4] = '{hsc_pkg::ADDR_TIMER_B, hsc_pkg::ADDR_SHUTDOWN,
		hsc_pkg::ADDR_SW_A, hsc_pkg::ADDR_SW_B};
	logic [7:0] msk [4] = '{8'h77, 8'h70, 8'h77, 8'h77};

	hsc_switch_ctrl #(.P_TICK_CYCLES(TK)) u_dut (.i_clk, .i_reset_n, .i_soft_reset,
		.i_wr_en, .i_rd_en, .i_addr, .i_wr_data, .o_rd_data, .i_timer_a_config,
		.i_pulse_a_duty, .i_pulse_b_duty, .i_supply_ov, .i_supply_uv, .i_overcurrent,
		.i_overtemp, .i_restart_clear, .i_cyclic_sense, .o_switch_on, .o_timer_a_clear);
	hsc_load_model u_load (.i_switch_on(o_switch_on), .i_short(short_q), .i_hot(hot_q),
		.o_overcurrent(i_overcurrent), .o_overtemp(i_overtemp));

	// 125 MHz core clock
	always #4 i_clk = ~i_clk;

	task automatic idle(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
		@(negedge i_clk);
		i_addr = a;
		i_wr_data = d;
		i_wr_en = 1'b1;
		@(negedge i_clk);
		i_wr_en = 1'b0;
	endtask
	// read data stands for one cycle after the read edge
	task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
		@(negedge i_clk);
		i_addr = a;
		i_rd_en = 1'b1;
		@(negedge i_clk);
		i_rd_en = 1'b0;
		`CHK($sformatf("register %0h", a), exp, o_rd_data)
	endtask
	task automatic sw_chk(input logic [3:0] exp);
		idle(2);
		`CHK("switch drive", exp, o_switch_on)
	endtask
	task automatic wait_lvl(input logic v, input int lim);
		int n;
		n = 0;
		while (o_switch_on[0] !== v && n < lim) begin
			@(negedge i_clk);
			n++;
		end
		if (n >= lim) `CHK("level wait", 1'b1, 1'b0)
	endtask
	// first pulse may be cut by the free-running tick, so time the second one
	task automatic measure(input int hi_exp, input int per_exp);
		int hi, lo;
		hi = 0;
		lo = 0;
		wait_lvl(1'b1, 20000);
		wait_lvl(1'b0, 20000);
		wait_lvl(1'b1, 20000);
		while (o_switch_on[0] === 1'b1 && hi < 20000) begin
			@(negedge i_clk);
			hi++;
		end
		while (o_switch_on[0] !== 1'b1 && lo < 20000) begin
			@(negedge i_clk);
			lo++;
		end
		`CHK("on cycles", hi_exp, hi)
		`CHK("period cycles", per_exp, hi + lo)
	endtask
	task automatic fault(input logic [7:0] sd, input logic ov, input logic [3:0] dur,
		input logic [3:0] aft, input logic [7:0] fld);
		wr_reg(hsc_pkg::ADDR_SW_A, 8'h01);
		wr_reg(hsc_pkg::ADDR_SHUTDOWN, sd);
		idle(1);
		i_supply_ov = ov;
		i_supply_uv = ~ov;
		sw_chk(dur);
		i_supply_ov = 1'b0;
		i_supply_uv = 1'b0;
		sw_chk(aft);
		rd_chk(hsc_pkg::ADDR_SW_A, fld);
	endtask
	task automatic restart(input logic cs, input logic [7:0] tmr);
		wr_reg(hsc_pkg::ADDR_TIMER_B, 8'h15);
		wr_reg(hsc_pkg::ADDR_SW_A, 8'h11);
		i_cyclic_sense = cs;
		i_restart_clear = 1'b1;
		idle(1);
		`CHK("timer a clear", cs, o_timer_a_clear)
		i_restart_clear = 1'b0;
		idle(1);
		rd_chk(hsc_pkg::ADDR_SW_A, 8'h00);
		rd_chk(hsc_pkg::ADDR_TIMER_B, tmr);
	endtask
	task automatic done(input string s);
		$display("test %s finished, mismatches so far %0d", s, err_count);
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// a hang counts as a mismatch; the planned run is about 52k cycles
	initial begin
		repeat (90000) @(posedge i_clk);
		err_count++;
		stop_test();
	end

	// main sequence
	initial begin
		idle(16);
		i_reset_n = 1'b1;
		for (int r = 0; r < 4; r++) rd_chk(adr[r], 8'h00);
		for (int r = 0; r < 4; r++) begin
			wr_reg(adr[r], 8'hff);
			rd_chk(adr[r], msk[r]);
		end
		wr_reg(7'h11, 8'hff);
		rd_chk(7'h11, 8'h00);
		i_soft_reset = 1'b1;
		idle(1);
		i_soft_reset = 1'b0;
		for (int r = 0; r < 4; r++) rd_chk(adr[r], 8'h00);
		done("registers");
		for (int k = 0; k < 4; k++) begin
			wr_reg(adr[2 + k / 2], (k % 2) ? 8'h10 : 8'h01);
			sw_chk(4'(4'h1 << k));
			wr_reg(adr[2 + k / 2], 8'h00);
		end
		wr_reg(hsc_pkg::ADDR_SW_A, 8'h76);
		sw_chk(4'h0);
		done("sources");
		wr_reg(hsc_pkg::ADDR_SW_A, 8'h03);
		for (int c = 1; c <= 5; c++) begin
			wr_reg(hsc_pkg::ADDR_TIMER_B, {1'b0, c[2:0], 4'h2});
			if (c > 1) sw_chk(4'h1);
			measure(on_t[c] * TK, per_t[2] * TK);
		end
		for (int p = 0; p <= 4; p++) begin
			wr_reg(hsc_pkg::ADDR_TIMER_B, {5'h02, p[2:0]});
			measure(on_t[1] * TK, per_t[p] * TK);
		end
		wr_reg(hsc_pkg::ADDR_TIMER_B, 8'h62);
		idle(60);
		sw_chk(4'h1);
		wr_reg(hsc_pkg::ADDR_TIMER_B, 8'h02);
		idle(60);
		sw_chk(4'h0);
		wr_reg(hsc_pkg::ADDR_SW_A, 8'h02);
		i_timer_a_config = 8'h20;
		measure(on_t[2] * TK, per_t[0] * TK);
		i_timer_a_config = 8'h00;
		wr_reg(hsc_pkg::ADDR_SW_A, 8'h00);
		done("timers");
		wr_reg(hsc_pkg::ADDR_SW_B, 8'h54);
		for (int d = 0; d < 2; d++) begin
			i_pulse_a_duty = d ? 8'h00 : 8'hff;
			i_pulse_b_duty = d ? 8'hff : 8'h00;
			idle(3);
			repeat (50) begin
				@(negedge i_clk);
				`CHK("pulse drive", d ? 2'b10 : 2'b01, o_switch_on[3:2])
			end
		end
		wr_reg(hsc_pkg::ADDR_SW_B, 8'h00);
		done("pulses");
		fault(8'h00, 1'b1, 4'h0, 4'h0, 8'h00);
		fault(8'h00, 1'b0, 4'h0, 4'h0, 8'h00);
		fault(8'h10, 1'b1, 4'h0, 4'h1, 8'h01);
		fault(8'h10, 1'b0, 4'h0, 4'h1, 8'h01);
		fault(8'h40, 1'b1, 4'h1, 4'h1, 8'h01);
		fault(8'h20, 1'b0, 4'h1, 4'h1, 8'h01);
		done("supply faults");
		wr_reg(hsc_pkg::ADDR_SW_A, 8'h11);
		short_q = 4'h1;
		idle(3);
		rd_chk(hsc_pkg::ADDR_SW_A, 8'h10);
		sw_chk(4'h2);
		short_q = 4'h0;
		hot_q = 4'h4;
		wr_reg(hsc_pkg::ADDR_SW_B, 8'h01);
		rd_chk(hsc_pkg::ADDR_SW_B, 8'h00);
		hot_q = 4'h0;
		done("hardware clears");
		restart(1'b0, 8'h15);
		restart(1'b1, 8'h00);
		done("restart");
		stop_test();
	end
endmodule // testbench
`default_nettype wire
